// ### pdb_pkg.sv
/*
 Shared constants for the pin input filter block: register offsets,
 field positions, reset values and sizes.
 Assumes an APB slave with 32-bit data and byte addresses.
*/
package pdb_pkg;
    // Geometry
    localparam int PDB_PORTS = 4;
    localparam int PDB_PINS = 8;
    localparam int PDB_ALL = PDB_PORTS * PDB_PINS;
    localparam int PDB_AW = 12;

    // Per-port filter enable registers
    localparam logic [11:0] PDB_OFF_EN0 = 12'h014;
    localparam logic [11:0] PDB_OFF_EN1 = 12'h054;
    localparam logic [11:0] PDB_OFF_EN2 = 12'h094;
    localparam logic [11:0] PDB_OFF_EN3 = 12'h0D4;
    // Per-port trigger type registers
    localparam logic [11:0] PDB_OFF_TY0 = 12'h018;
    localparam logic [11:0] PDB_OFF_TY1 = 12'h058;
    localparam logic [11:0] PDB_OFF_TY2 = 12'h098;
    localparam logic [11:0] PDB_OFF_TY3 = 12'h0D8;
    // Shared control, event status and event mask
    localparam logic [11:0] PDB_OFF_CTL = 12'h180;
    localparam logic [11:0] PDB_OFF_STS = 12'h184;
    localparam logic [11:0] PDB_OFF_MSK = 12'h188;

    // Shared control fields
    localparam int PDB_CTL_SRC_BIT = 4;
    localparam int PDB_CTL_SEL_LSB = 0;
    localparam int PDB_CTL_SEL_W = 4;
    localparam int PDB_CTL_W = 5;

    // Reset values
    localparam logic [7:0] PDB_EN_RST = 8'h00;
    localparam logic [7:0] PDB_TY_RST = 8'h00;
    localparam logic [4:0] PDB_CTL_RST = 5'h00;
    localparam logic [31:0] PDB_STS_RST = 32'h00000000;
    localparam logic [31:0] PDB_MSK_RST = 32'h00000000;

    // Trigger type codes
    localparam logic PDB_TYPE_EDGE = 1'b0;
    localparam logic PDB_TYPE_LEVEL = 1'b1;

    // Consecutive equal samples needed to accept a level
    localparam int PDB_STABLE_SAMPLES = 2;
    // Width of the sample period counter: periods up to 2**15 source ticks
    localparam int PDB_DIV_W = 16;
endpackage

// ### pdb_filter.sv
/*
 Pin input filter and interrupt event logic for four eight-pin ports,
 with its APB register slave.
 Assumes pins may change at any time relative to clk, and that slow_tick is a
 one-cycle strobe in the clk domain from a slower reference clock.
*/
// Notes on behaviour
// - One filter enable bit per pin
// - New level must hold two samples
// - Control bit 4 selects filter source
// - Control bits 3:0 set sample period
// - Filtering only for edge-triggered pins
// - Eight enable bits, upper bits reserved
// - Enable registers reset to zero
// - Type bit: 0 edge, 1 level
// - Level mode uses one-clock sample
`timescale 1ns/1ps
module pdb_filter
    import pdb_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [31:0] pin_in,
    input wire logic slow_tick,
    output logic [31:0] pin_level,
    output logic irq
);

    // Register storage: one byte per port for enable and type, then shared control, status and mask
    logic [7:0] port_filter_enable_register [PDB_PORTS];
    logic [7:0] trigger_type [PDB_PORTS];
    logic [4:0] shared_filter_control_register;
    logic [31:0] event_status;
    logic [31:0] event_mask;

    // Pin synchroniser and filter state
    logic [31:0] pin_meta;     // First stage, read by pin_sync only
    logic [31:0] pin_sync;     // Second stage
    logic [31:0] sample_prev;  // Previous filter sample
    logic [31:0] sample_cur;   // Latest filter sample
    logic [31:0] stable;       // Accepted filtered level
    logic [31:0] qual_prev;    // Qualified level one clock ago
    logic [PDB_DIV_W-1:0] div_cnt; // Sample period counter
    logic sample_tick;         // One pulse per sample period
    logic [3:0] period_sel; // Period select field of the control register
    logic [PDB_DIV_W-1:0] period_len; // Source ticks per sample period

    // Flattened views of per-port bytes, plus per-pin qualified level, event and status-clear vectors
    logic [31:0] en_flat;
    logic [31:0] type_flat;
    logic [31:0] next_qual;
    logic [31:0] next_events;
    logic [31:0] sts_clear;

    // Bus decode helpers
    logic access;
    logic wr_done;
    logic [31:0] next_rdata;
    logic next_err;

    // Which port a per-port offset belongs to, or -1
    function automatic int port_of(input logic [11:0] a, input logic [11:0] base0);
        int p;
        port_of = -1;
        for (p = 0; p < PDB_PORTS; p++) begin
            if (a == base0 + 12'(p * 'h40)) begin
                port_of = p;
            end
        end
    endfunction

    // Period length in source ticks: 2**sel
    function automatic logic [PDB_DIV_W-1:0] period_of(input logic [3:0] sel);
        period_of = PDB_DIV_W'(1) << sel;
    endfunction

    // Flatten per-port bytes
    // Bit port*8+pin, the same order as status and mask
    always_comb begin
        en_flat = '0;
        type_flat = '0;
        for (int p = 0; p < PDB_PORTS; p++) begin
            en_flat[p*PDB_PINS +: PDB_PINS] = port_filter_enable_register[p];
            type_flat[p*PDB_PINS +: PDB_PINS] = trigger_type[p];
        end
    end

    // Setup phase seen; answer comes on the next edge
    // A write lands at the access edge, where pready is seen high
    assign access = psel && !penable;
    assign wr_done = psel && penable && pready && pwrite && !pslverr;

    // Reserved bits read zero; unmapped offsets answer with an error
    // Read mux and unmapped-address check
    always_comb begin
        int pe;
        int pt;
        pe = port_of(paddr, PDB_OFF_EN0);
        pt = port_of(paddr, PDB_OFF_TY0);
        next_rdata = 32'h00000000;
        next_err = 1'b0;
        if (pe >= 0) begin
            next_rdata = {24'h000000, port_filter_enable_register[pe[1:0]]};
        end else if (pt >= 0) begin
            next_rdata = {24'h000000, trigger_type[pt[1:0]]};
        end else if (paddr == PDB_OFF_CTL) begin
            next_rdata = {27'h0000000, shared_filter_control_register};
        end else if (paddr == PDB_OFF_STS) begin
            next_rdata = event_status;
        end else if (paddr == PDB_OFF_MSK) begin
            next_rdata = event_mask;
        end else begin
            // Unmapped: error answer, zero data
            next_err = 1'b1;
        end
    end

    // APB answer registers: no wait state, pready one cycle wide
    // Registered answer keeps the decode path off the bus outputs
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= access;
            if (access) begin
                pslverr <= next_err;
                prdata <= pwrite ? 32'h00000000 : next_rdata;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // Per-port enable and type registers
    // Reserved upper bits of each write are dropped here
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            for (int p = 0; p < PDB_PORTS; p++) begin
                port_filter_enable_register[p] <= PDB_EN_RST;
                trigger_type[p] <= PDB_TY_RST;
            end
        end else if (wr_done) begin
            for (int p = 0; p < PDB_PORTS; p++) begin
                // one bit per pin, 1 enables
                if (paddr == PDB_OFF_EN0 + 12'(p * 'h40)) begin
                    port_filter_enable_register[p] <= pwdata[7:0];
                end
                if (paddr == PDB_OFF_TY0 + 12'(p * 'h40)) begin
                    trigger_type[p] <= pwdata[7:0];
                end
            end
        end
    end

    // Shared control and mask registers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            shared_filter_control_register <= PDB_CTL_RST;
            event_mask <= PDB_MSK_RST;
        end else if (wr_done) begin
            if (paddr == PDB_OFF_CTL) begin
                shared_filter_control_register <= pwdata[PDB_CTL_W-1:0];
            end
            if (paddr == PDB_OFF_MSK) begin
                event_mask <= pwdata;
            end
        end
    end

    // Pins may move at any time; two flops hold metastability back
    // two-flop synchroniser before the filter
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pin_meta <= 32'h00000000;
            pin_sync <= 32'h00000000;
        end else begin
            pin_meta <= pin_in;
            pin_sync <= pin_meta;
        end
    end

    // Period fields; 2**sel keeps a wide range in one small counter,
    // at the price of coarse steps
    assign period_sel = shared_filter_control_register[PDB_CTL_SEL_LSB +: PDB_CTL_SEL_W];
    assign period_len = period_of(period_sel);

    // Sample period divider
    // Restarts at or past the end, so a shorter period written
    // mid-count takes effect at once instead of wrapping around
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            div_cnt <= '0;
            sample_tick <= 1'b0;
        end else begin
            sample_tick <= 1'b0;
            // source is bus clock or slow tick
            if (!shared_filter_control_register[PDB_CTL_SRC_BIT] || slow_tick) begin
                if (div_cnt >= period_len - 1'b1) begin
                    div_cnt <= '0;
                    sample_tick <= 1'b1;
                end else begin
                    div_cnt <= div_cnt + 1'b1;
                end
            end
        end
    end

    // Two-sample stability check per pin
    // A lone changed sample never moves the level, so bounce
    // no longer than one sample period simply vanishes
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sample_prev <= 32'h00000000;
            sample_cur <= 32'h00000000;
            stable <= 32'h00000000;
        end else begin
            if (sample_tick) begin
                sample_prev <= sample_cur;
                sample_cur <= pin_sync;
            end
            for (int i = 0; i < PDB_ALL; i++) begin
                if (!en_flat[i]) begin
                    // Filter off: track the pin so enabling makes no false edge
                    stable[i] <= pin_sync[i];
                end else if (sample_tick && sample_cur[i] == sample_prev[i]) begin
                    // accept only after two equal samples
                    stable[i] <= sample_cur[i];
                end
            end
        end
    end

    // Qualified level per pin
    // Level pins bypass the filter whatever their enable says
    always_comb begin
        for (int i = 0; i < PDB_ALL; i++) begin
            // level pins use the plain clock sample
            if (type_flat[i] == PDB_TYPE_EDGE && en_flat[i]) begin
                next_qual[i] = stable[i];
            end else begin
                next_qual[i] = pin_sync[i];
            end
        end
    end

    // Events: any edge for edge pins, high level for level pins
    // Level pins re-set status while high; a clear sticks once low
    always_comb begin
        for (int i = 0; i < PDB_ALL; i++) begin
            if (type_flat[i] == PDB_TYPE_LEVEL) begin
                next_events[i] = next_qual[i];
            end else begin
                next_events[i] = next_qual[i] ^ qual_prev[i];
            end
        end
    end

    // Edge detector history and visible level
    // History resets low to match idle pins, so no false edge
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            qual_prev <= 32'h00000000;
            pin_level <= 32'h00000000;
        end else begin
            qual_prev <= next_qual;
            pin_level <= next_qual;
        end
    end

    // Write-one-to-clear bits of the status register
    assign sts_clear = (wr_done && paddr == PDB_OFF_STS) ? pwdata : 32'h00000000;

    // Sticky status; a new event wins over a clear
    // so that an event in the clearing cycle is never lost
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            event_status <= PDB_STS_RST;
        end else begin
            event_status <= (event_status & ~sts_clear) | next_events;
        end
    end

    // Interrupt output, registered
    // Built from the next status so irq moves with status, no lag
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((event_status & ~sts_clear) | next_events) & event_mask);
        end
    end

endmodule

// ### pdb_pin_model.sv
/*
 Pin and slow-tick source facing the filter block's pin inputs.
 Assumes tb sets pin_drive and tick_on right after a rising edge.
*/
`timescale 1ns/1ps
module pdb_pin_model (
    input wire logic clk,
    input wire logic [31:0] pin_drive,
    input wire logic tick_on,
    output logic [31:0] pin_in,
    output logic slow_tick
);
    logic [1:0] div = 2'h0; // Tick divider
    // Pins follow requested levels one edge later
    always @(posedge clk) begin
        pin_in <= pin_drive;
    end
    // One tick every four clocks; no tick when off, divider keeps counting
    always @(posedge clk) begin
        div <= div + 2'h1;
        slow_tick <= tick_on && (div == 2'h3);
    end
endmodule

// ### pdb_filter_asserts.sv
/*
 Port assertions for the filter block: bus timing and interrupt.
 Assumes binding to pdb_filter; sees its ports only.
*/
`timescale 1ns/1ps
module pdb_filter_asserts (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Setup cycle of a transfer
    sequence apb_setup;
        psel && !penable;
    endsequence
    // A finished write
    sequence wr_done;
        pready && pwrite;
    endsequence
    rdy_after_setup_a:
        assert property (apb_setup |=> pready) else $error("ready late");
    rdy_one_cycle_a:
        assert property (pready |=> !pready) else $error("ready too long");
    rdy_in_access_a:
        assert property (pready |-> psel && penable) else $error("stray ready");
    err_with_rdy_a:
        assert property (pslverr |-> pready) else $error("stray error");
    err_read_zero_a:
        assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
            else $error("error read not zero");
    rdata_hold_a:
        assert property ($changed(prdata) |-> $past(psel) && !$past(penable))
            else $error("read data moved");
    reset_quiet_a:
        assert property (!$past(rst_b) |-> !irq && !pready && prdata == 32'h0)
            else $error("outputs not clear");
    irq_fall_a:
        assert property ($fell(irq) |-> ($past(pready) && $past(pwrite))
            || ($past(pready, 2) && $past(pwrite, 2))
            || ($past(pready, 3) && $past(pwrite, 3)))
            else $error("irq fell without write");
    wr_zero_data_a:
        assert property (wr_done |-> prdata == 32'h0) else $error("write returned data");
endmodule
bind pdb_filter pdb_filter_asserts pdb_filter_asserts_inst (.clk(clk), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq));

// ### tb.sv
/*
 Self-checking bench for the pin input filter block.
 Assumes pdb_pin_model drives pins; registers via APB tasks.
*/
`timescale 1ns/1ps
module tb;
    import pdb_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, tick_on = 1'b0; // Clock, reset, tick gate
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // Bus controls
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, pins = 32'h0, rd; // Write data, pins, last read
    logic [31:0] prdata, pin_in, pin_level;
    logic pready, pslverr, slow_tick, irq, er; // er: last error flag
    int err_count = 0, cmp_count = 0;
    typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] r;} pdb_row_s;
    // Address, write value, read-back; reserved bits must read 0
    pdb_row_s rows [7] = '{'{PDB_OFF_EN0, 32'hFFFF_FF5A, 32'h5A},
        '{PDB_OFF_EN1, 32'hFFFF_FFA5, 32'hA5}, '{PDB_OFF_EN2, 32'h3C, 32'h3C},
        '{PDB_OFF_EN3, 32'hFFFF_FFFF, 32'hFF}, '{PDB_OFF_TY0, 32'hFFFF_FF0F, 32'h0F},
        '{PDB_OFF_CTL, 32'hFFFF_FFEF, 32'h0F}, '{PDB_OFF_MSK, 32'hFFFF_FFFF, 32'hFFFF_FFFF}};
    always #20 clk = ~clk;
    pdb_pin_model pdb_pin_model_inst (.clk(clk), .pin_drive(pins), .tick_on(tick_on),
        .pin_in(pin_in), .slow_tick(slow_tick));
    pdb_filter pdb_filter_inst (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_in(pin_in), .slow_tick(slow_tick), .pin_level(pin_level),
        .irq(irq));
    // Compare one word
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    // One transfer; only the watchdog ends a hang
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Drive pins high for len clocks
    task pulse(input logic [31:0] m, input int len);
        @(posedge clk);
        pins <= m;
        repeat (len) @(posedge clk);
        pins <= 32'h0;
    endtask
    // Let events settle, check irq and status, then clear status
    task sts(input logic [31:0] e, input logic ei);
        repeat (30) @(posedge clk);
        chk("irq", {31'h0, ei}, {31'h0, irq});
        apb(1'b0, PDB_OFF_STS, 32'h0);
        chk("status", e, rd);
        apb(1'b1, PDB_OFF_STS, 32'hFFFF_FFFF);
    endtask
    task finish_test;
        if (err_count == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Watchdog: run needs well under 5000 clocks
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        finish_test;
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        foreach (rows[i]) begin
            apb(1'b0, rows[i].a, 32'h0);
            chk("reset value", 32'h0, rd);
        end
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].w);
            apb(1'b0, rows[i].a, 32'h0);
            chk("read back", rows[i].r, rd);
        end
        apb(1'b0, 12'hFFC, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        // Pin 0 plain edge, pin 1 filtered edge, pin 2 level with enable set, so unfiltered
        apb(1'b1, PDB_OFF_EN0, 32'h06);
        apb(1'b1, PDB_OFF_TY0, 32'h04);
        apb(1'b1, PDB_OFF_CTL, 32'h02);
        apb(1'b1, PDB_OFF_MSK, 32'h0);
        apb(1'b1, PDB_OFF_STS, 32'hFFFF_FFFF);
        pulse(32'h7, 3);
        sts(32'h5, 1'b0);
        pulse(32'h2, 20);
        sts(32'h2, 1'b0);
        apb(1'b1, PDB_OFF_CTL, 32'h00);
        apb(1'b1, PDB_OFF_MSK, 32'h2);
        pulse(32'h2, 3);
        sts(32'h2, 1'b1);
        apb(1'b1, PDB_OFF_CTL, 32'h10);
        pulse(32'h2, 20);
        sts(32'h0, 1'b0);
        tick_on <= 1'b1;
        pulse(32'h2, 20);
        sts(32'h2, 1'b1);
        // Filter off for pin 1, so a short pulse counts again
        apb(1'b1, PDB_OFF_EN0, 32'h0);
        pulse(32'h2, 1);
        sts(32'h2, 1'b1);
        // Unfiltered pin: level after sync, then irq through the mask
        apb(1'b1, PDB_OFF_MSK, 32'h0001_0000);
        @(posedge clk);
        pins <= 32'h0001_0000;
        repeat (5) @(posedge clk);
        chk("pin level", 32'h0001_0000, pin_level);
        chk("irq", 32'h1, {31'h0, irq});
        pins <= 32'h0;
        // Mid-run reset clears registers, status and outputs
        repeat (5) @(posedge clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        chk("irq reset", 32'h0, {31'h0, irq});
        chk("level reset", 32'h0, pin_level);
        apb(1'b0, PDB_OFF_EN1, 32'h0);
        chk("enable reset", 32'h0, rd);
        apb(1'b0, PDB_OFF_STS, 32'h0);
        chk("status reset", 32'h0, rd);
        finish_test;
    end
endmodule
